// ==== verilog/io_space_pkg.sv ====
/*
  Constants for the I/O register space decoder: window bases, register
  offsets, implemented-bit masks and the access class of every location.
  Assumes an 8-bit core with a 64-location direct I/O window.
*/
`default_nettype none
package io_space_pkg;

  // ************************************************************
  // Widths and windows
  // ************************************************************
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned IO_ADDR_W   = 6;
  localparam int unsigned BIT_ADDR_W  = 5;
  localparam int unsigned DS_ADDR_W   = 8;
  localparam int unsigned IO_LOCS     = 64;
  localparam logic [7:0]  DS_IO_BASE  = 8'h20;
  localparam logic [7:0]  DS_EXT_BASE = 8'h60;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  ONE_BIT     = 8'h01;

  // ************************************************************
  // Register offsets in the direct I/O window
  // ************************************************************
  localparam logic [5:0] OFF_PORT_A_INPUT     = 6'h00;
  localparam logic [5:0] OFF_PORT_A_DIRECTION = 6'h01;
  localparam logic [5:0] OFF_PORT_A_OUTPUT    = 6'h02;
  localparam logic [5:0] OFF_PORT_B_INPUT     = 6'h03;
  localparam logic [5:0] OFF_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] OFF_PORT_B_OUTPUT    = 6'h05;
  localparam logic [5:0] OFF_PORT_C_INPUT     = 6'h06;
  localparam logic [5:0] OFF_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] OFF_PORT_C_OUTPUT    = 6'h08;
  localparam logic [5:0] OFF_PORT_D_INPUT     = 6'h09;
  localparam logic [5:0] OFF_PORT_D_DIRECTION = 6'h0a;
  localparam logic [5:0] OFF_PORT_D_OUTPUT    = 6'h0b;
  localparam logic [5:0] OFF_TIMER0_FLAGS     = 6'h15;
  localparam logic [5:0] OFF_TIMER1_FLAGS     = 6'h16;
  localparam logic [5:0] OFF_TIMER2_FLAGS     = 6'h17;
  localparam logic [5:0] OFF_PIN_CHANGE_FLAGS = 6'h1b;
  localparam logic [5:0] OFF_EXT_IRQ_FLAGS    = 6'h1c;
  localparam logic [5:0] OFF_EXT_IRQ_MASK     = 6'h1d;
  localparam logic [5:0] OFF_NVM_CONTROL      = 6'h1f;

  // ************************************************************
  // Implemented bits per location; zero marks a reserved address
  // ************************************************************
  function automatic logic [7:0] impl_mask(input logic [5:0] a);
    case (a)
      6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
      6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b: impl_mask = 8'hff;
      6'h15: impl_mask = 8'h07;
      6'h16: impl_mask = 8'h27;
      6'h17: impl_mask = 8'h07;
      6'h1b: impl_mask = 8'h0f;
      6'h1c: impl_mask = 8'h07;
      6'h1d: impl_mask = 8'h07;
      6'h1e: impl_mask = 8'hff;
      6'h1f: impl_mask = 8'h3f;
      6'h20, 6'h21: impl_mask = 8'hff;
      6'h22: impl_mask = 8'h0f;
      6'h23: impl_mask = 8'h83;
      6'h24: impl_mask = 8'hf3;
      6'h25: impl_mask = 8'hcf;
      6'h26, 6'h27, 6'h28, 6'h2a, 6'h2b, 6'h2c: impl_mask = 8'hff;
      6'h2d: impl_mask = 8'hc1;
      6'h2e, 6'h30, 6'h31: impl_mask = 8'hff;
      default: impl_mask = 8'h00;
    endcase
  endfunction

  // Locations whose implemented bits are write-one-to-clear flags
  function automatic logic is_w1c(input logic [5:0] a);
    is_w1c = (a == OFF_TIMER0_FLAGS) || (a == OFF_TIMER1_FLAGS) ||
             (a == OFF_TIMER2_FLAGS) || (a == OFF_PIN_CHANGE_FLAGS) ||
             (a == OFF_EXT_IRQ_FLAGS);
  endfunction

  // Port input locations read the synchronised pins
  function automatic logic is_pin(input logic [5:0] a);
    is_pin = (a == OFF_PORT_A_INPUT) || (a == OFF_PORT_B_INPUT) ||
             (a == OFF_PORT_C_INPUT) || (a == OFF_PORT_D_INPUT);
  endfunction

endpackage
`default_nettype wire

// ==== verilog/io_space_register_decode.sv ====
/*
  I/O register space decoder: one 64-location register window reached by
  direct I/O accesses, single-bit operations (lower 32 locations only) and
  the data-space alias, with the extended window forwarded to an outside decoder.
  Assumes one core clock, the core issues at most one access per cycle, and
  the extended-space decoder answers its read data in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module io_space_register_decode (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Direct I/O access
  input  wire logic [5:0] io_addr_i,
  input  wire logic       io_rd_i,
  input  wire logic       io_wr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  // Single-bit operations
  input  wire logic [4:0] bit_addr_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic       io_bit_set_op_i,
  input  wire logic       io_bit_clear_op_i,
  input  wire logic       skip_if_io_bit_set_i,
  input  wire logic       skip_if_io_bit_clear_i,
  output logic            skip_o,
  // Data-space access
  input  wire logic [7:0] ds_addr_i,
  input  wire logic       data_space_load_i,
  input  wire logic       data_space_store_i,
  input  wire logic [7:0] ds_wdata_i,
  output logic      [7:0] ds_rdata_o,
  // Extended space decoder
  output logic            ext_load_o,
  output logic            ext_store_o,
  output logic      [7:0] ext_addr_o,
  output logic      [7:0] ext_wdata_o,
  input  wire logic [7:0] ext_rdata_i,
  // Port pins
  input  wire logic [7:0] pin_a_i,
  input  wire logic [7:0] pin_b_i,
  input  wire logic [7:0] pin_c_i,
  input  wire logic [7:0] pin_d_i,
  output logic      [7:0] port_a_dir_o,
  output logic      [7:0] port_a_out_o,
  output logic      [7:0] port_b_dir_o,
  output logic      [7:0] port_b_out_o,
  output logic      [7:0] port_c_dir_o,
  output logic      [7:0] port_c_out_o,
  output logic      [7:0] port_d_dir_o,
  output logic      [7:0] port_d_out_o,
  // Flag events from the peripherals
  input  wire logic [7:0] timer0_flag_set_i,
  input  wire logic [7:0] timer1_flag_set_i,
  input  wire logic [7:0] timer2_flag_set_i,
  input  wire logic [7:0] pin_change_flag_set_i,
  input  wire logic [7:0] ext_irq_flag_set_i,
  output logic      [7:0] timer0_flags_o,
  output logic      [7:0] timer1_flags_o,
  output logic      [7:0] timer2_flags_o,
  output logic      [7:0] pin_change_flags_o,
  output logic      [7:0] ext_irq_flags_o,
  output logic      [7:0] ext_irq_mask_o,
  // Write notification to the peripherals
  output logic            reg_wr_o,
  output logic      [5:0] reg_wr_addr_o,
  output logic      [7:0] reg_wr_data_o
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [7:0] pin_meta_r [4];
  logic [7:0] pin_sync_r [4];
  logic [7:0] pin_raw    [4];

  assign pin_raw[0] = pin_a_i;
  assign pin_raw[1] = pin_b_i;
  assign pin_raw[2] = pin_c_i;
  assign pin_raw[3] = pin_d_i;

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_pin
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          pin_meta_r[p] <= io_space_pkg::ZERO_BYTE;
          pin_sync_r[p] <= io_space_pkg::ZERO_BYTE;
        end else begin
          pin_meta_r[p] <= pin_raw[p];
          pin_sync_r[p] <= pin_meta_r[p];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Access decode
  // ************************************************************
  logic [7:0] regs_r  [io_space_pkg::IO_LOCS];
  logic [7:0] cur_val [io_space_pkg::IO_LOCS];
  logic [7:0] hw_set  [io_space_pkg::IO_LOCS];

  wire        bit_wr     = io_bit_set_op_i | io_bit_clear_op_i;
  wire        bit_test   = skip_if_io_bit_set_i | skip_if_io_bit_clear_i;
  wire        bit_any    = bit_wr | bit_test;
  wire        io_any     = io_rd_i | io_wr_i;
  wire        ds_any     = data_space_load_i | data_space_store_i;

  // The data-space alias covers 0x20..0x5F; below is the working file
  wire        ds_io_hit  = (ds_addr_i >= io_space_pkg::DS_IO_BASE) &&
                           (ds_addr_i <  io_space_pkg::DS_EXT_BASE);
  wire        ds_ext_hit = ds_addr_i >= io_space_pkg::DS_EXT_BASE;
  wire [7:0]  ds_io_off  = ds_addr_i - io_space_pkg::DS_IO_BASE;

  // Bit operations carry only a 5-bit address: upper 32 unreachable
  wire [5:0]  bit_loc    = {1'b0, bit_addr_i};
  wire [7:0]  bit_mask   = io_space_pkg::ONE_BIT << bit_sel_i;

  // One access per cycle; bit operations, then direct I/O, then data space
  wire        sel_bit    = bit_any;
  wire        sel_io     = !bit_any && io_any;
  wire        sel_ds     = !bit_any && !io_any && ds_any;

  // Direct I/O uses the full 6-bit opcode field
  wire [5:0]  acc_addr   = sel_bit ? bit_loc :
                           sel_io  ? io_addr_i :
                                     ds_io_off[5:0];
  wire [7:0]  acc_cur    = cur_val[acc_addr];

  // Read-modify-write of the whole register value as read
  wire [7:0]  bit_wval   = io_bit_set_op_i ? (acc_cur | bit_mask) :
                                             (acc_cur & ~bit_mask);

  wire        acc_wr     = (sel_bit && bit_wr) ||
                           (sel_io && io_wr_i) ||
                           (sel_ds && data_space_store_i && ds_io_hit);
  wire [7:0]  acc_wdata  = sel_bit ? bit_wval :
                           sel_io  ? io_wdata_i : ds_wdata_i;

  // Reserved locations take no write at all
  wire [7:0]  acc_impl   = io_space_pkg::impl_mask(acc_addr);
  wire        acc_wr_ok  = acc_wr && (acc_impl != io_space_pkg::ZERO_BYTE);

  wire        test_bit   = |(acc_cur & bit_mask);
  wire        skip_nxt   = (skip_if_io_bit_set_i && test_bit) ||
                           (skip_if_io_bit_clear_i && !test_bit);

  wire        ds_ext_ld  = sel_ds && data_space_load_i && ds_ext_hit;
  wire        ds_ext_st  = sel_ds && data_space_store_i && ds_ext_hit;

  // ************************************************************
  // Register storage, one entry per location
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < io_space_pkg::IO_LOCS; i++) begin : g_reg
      localparam logic [5:0] LOC  = 6'(i);
      localparam logic [7:0] MASK = io_space_pkg::impl_mask(LOC);
      localparam logic       W1C  = io_space_pkg::is_w1c(LOC);
      localparam logic       PIN  = io_space_pkg::is_pin(LOC);

      wire        hit      = acc_wr_ok && (acc_addr == LOC);
      wire [7:0]  clr_bits = hit ? acc_wdata : io_space_pkg::ZERO_BYTE;
      logic [7:0] nxt;

      assign hw_set[i] =
        (LOC == io_space_pkg::OFF_TIMER0_FLAGS)     ? timer0_flag_set_i :
        (LOC == io_space_pkg::OFF_TIMER1_FLAGS)     ? timer1_flag_set_i :
        (LOC == io_space_pkg::OFF_TIMER2_FLAGS)     ? timer2_flag_set_i :
        (LOC == io_space_pkg::OFF_PIN_CHANGE_FLAGS) ? pin_change_flag_set_i :
        (LOC == io_space_pkg::OFF_EXT_IRQ_FLAGS)    ? ext_irq_flag_set_i :
                                                      io_space_pkg::ZERO_BYTE;

      // Flags: one clears, zero keeps, a new event wins over the clear
      if (W1C) begin : g_w1c
        assign nxt = ((regs_r[i] & ~clr_bits) | hw_set[i]) & MASK;
      end else if (PIN) begin : g_ro
        assign nxt = io_space_pkg::ZERO_BYTE;
      end else begin : g_rw
        assign nxt = hit ? (acc_wdata & MASK) : regs_r[i];
      end

      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          regs_r[i] <= io_space_pkg::ZERO_BYTE;
        end else begin
          regs_r[i] <= nxt;
        end
      end

      // Reserved bits and reserved addresses read as zero
      if (PIN) begin : g_pin_rd
        assign cur_val[i] = pin_sync_r[i / 3];
      end else begin : g_reg_rd
        assign cur_val[i] = regs_r[i] & MASK;
      end
    end
  endgenerate

  // ************************************************************
  // Read data and answers
  // ************************************************************
  wire [7:0] io_rdata_nxt = sel_io && io_rd_i ? acc_cur : io_rdata_o;
  wire [7:0] ds_rdata_nxt = !(sel_ds && data_space_load_i) ? ds_rdata_o :
                            ds_io_hit  ? acc_cur :
                            ds_ext_hit ? ext_rdata_i :
                                         io_space_pkg::ZERO_BYTE;

  // Direct read data holds until the next direct read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= io_space_pkg::ZERO_BYTE;
    end else begin
      io_rdata_o <= io_rdata_nxt;
    end
  end

  // Load data holds until the next load
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ds_rdata_o <= io_space_pkg::ZERO_BYTE;
    end else begin
      ds_rdata_o <= ds_rdata_nxt;
    end
  end

  // ************************************************************
  // Skip answer
  // ************************************************************
  // High for one cycle only after a test whose condition held
  wire       skip_fire = sel_bit && bit_test && skip_nxt;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      skip_o <= 1'b0;
    end else begin
      skip_o <= skip_fire;
    end
  end

  // ************************************************************
  // Write notice to the peripherals
  // ************************************************************
  // A bit operation reports the whole rewritten byte
  wire [7:0] note_data = acc_wdata & acc_impl;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_wr_o <= 1'b0;
    end else begin
      reg_wr_o <= acc_wr_ok;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_wr_addr_o <= 6'h00;
      reg_wr_data_o <= io_space_pkg::ZERO_BYTE;
    end else begin
      reg_wr_addr_o <= acc_addr;
      reg_wr_data_o <= note_data;
    end
  end

  // ************************************************************
  // Extended space forwarding
  // ************************************************************
  assign ext_load_o  = ds_ext_ld;
  assign ext_store_o = ds_ext_st;
  assign ext_addr_o  = ds_addr_i;
  assign ext_wdata_o = ds_wdata_i;

  // ************************************************************
  // Register outputs to the peripherals
  // ************************************************************
  assign port_a_dir_o       = regs_r[io_space_pkg::OFF_PORT_A_DIRECTION];
  assign port_a_out_o       = regs_r[io_space_pkg::OFF_PORT_A_OUTPUT];
  assign port_b_dir_o       = regs_r[io_space_pkg::OFF_PORT_B_DIRECTION];
  assign port_b_out_o       = regs_r[io_space_pkg::OFF_PORT_B_OUTPUT];
  assign port_c_dir_o       = regs_r[io_space_pkg::OFF_PORT_C_DIRECTION];
  assign port_c_out_o       = regs_r[io_space_pkg::OFF_PORT_C_OUTPUT];
  assign port_d_dir_o       = regs_r[io_space_pkg::OFF_PORT_D_DIRECTION];
  assign port_d_out_o       = regs_r[io_space_pkg::OFF_PORT_D_OUTPUT];
  assign timer0_flags_o     = regs_r[io_space_pkg::OFF_TIMER0_FLAGS];
  assign timer1_flags_o     = regs_r[io_space_pkg::OFF_TIMER1_FLAGS];
  assign timer2_flags_o     = regs_r[io_space_pkg::OFF_TIMER2_FLAGS];
  assign pin_change_flags_o = regs_r[io_space_pkg::OFF_PIN_CHANGE_FLAGS];
  assign ext_irq_flags_o    = regs_r[io_space_pkg::OFF_EXT_IRQ_FLAGS];
  assign ext_irq_mask_o     = regs_r[io_space_pkg::OFF_EXT_IRQ_MASK];

endmodule
`default_nettype wire

// ==== testbench/io_space_checker_assertions.sv ====
/*
  Checker for the I/O space decoder: access windows, flags and notices.
  Assumes it sees only the decoder's top-level ports, bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module io_space_checker (
  // Clock, reset and requests
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic [5:0] io_addr_i,
  input wire logic       io_rd_i,
  input wire logic       io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [4:0] bit_addr_i,
  input wire logic       io_bit_set_op_i,
  input wire logic       io_bit_clear_op_i,
  input wire logic       skip_if_io_bit_set_i,
  input wire logic       skip_if_io_bit_clear_i,
  input wire logic [7:0] ds_addr_i,
  input wire logic       data_space_load_i,
  input wire logic       data_space_store_i,
  input wire logic [7:0] ds_wdata_i,
  input wire logic [7:0] ext_rdata_i,
  input wire logic [7:0] timer0_flag_set_i,
  // Observed outputs
  input wire logic [7:0] io_rdata_o,
  input wire logic [7:0] ds_rdata_o,
  input wire logic       skip_o,
  input wire logic       ext_load_o,
  input wire logic       ext_store_o,
  input wire logic [7:0] port_a_dir_o,
  input wire logic [7:0] timer0_flags_o,
  input wire logic       reg_wr_o,
  input wire logic [5:0] reg_wr_addr_o
);
  logic bop;
  logic dsok;
  // Data-space requests count only when nothing of higher priority is asked
  assign bop  = io_bit_set_op_i | io_bit_clear_op_i |
                skip_if_io_bit_set_i | skip_if_io_bit_clear_i;
  assign dsok = !bop && !io_rd_i && !io_wr_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  ext_load_a: assert property (ext_load_o |-> data_space_load_i && ds_addr_i >= 8'h60)
    else $error("extended load without a data-space load");
  ext_store_a: assert property (ext_store_o |-> data_space_store_i && ds_addr_i >= 8'h60)
    else $error("extended store without a data-space store");
  ext_data_a: assert property (dsok && data_space_load_i && ds_addr_i >= 8'h60
    |=> ds_rdata_o == $past(ext_rdata_i)) else $error("extended load data lost");
  alias_wr_a: assert property (dsok && data_space_store_i && ds_addr_i == 8'h21
    |=> port_a_dir_o == $past(ds_wdata_i)) else $error("alias store missed its register");
  low_ds_a: assert property (dsok && data_space_load_i && ds_addr_i < 8'h20
    |=> ds_rdata_o == 8'h00) else $error("load below the window not zero");
  flag_w1c_a: assert property (!bop && io_wr_i && io_addr_i == 6'h15 &&
    timer0_flag_set_i == 8'h00 |=> timer0_flags_o == ($past(timer0_flags_o) & ~$past(io_wdata_i)))
    else $error("flag write is not write-one-to-clear");
  bit_rmw_a: assert property (io_bit_set_op_i && bit_addr_i == 5'h15 &&
    timer0_flag_set_i == 8'h00 |=> timer0_flags_o == 8'h00) else $error("bit set kept a flag");
  skip_idle_a: assert property (!(skip_if_io_bit_set_i || skip_if_io_bit_clear_i)
    |=> !skip_o) else $error("skip without a bit test");
  rsv_rd_a: assert property (!bop && io_rd_i && io_addr_i == 6'h0c
    |=> io_rdata_o == 8'h00) else $error("reserved read not zero");
  wr_note_a: assert property (!bop && io_wr_i && io_addr_i == 6'h1e
    |=> reg_wr_o && reg_wr_addr_o == 6'h1e) else $error("direct write gave no notice");
  cover property (ext_load_o);
  cover property (skip_o);
  cover property (reg_wr_o && reg_wr_addr_o == 6'h15);
endmodule
bind io_space_register_decode io_space_checker i_io_space_checker (.*);
`default_nettype wire

// ==== testbench/ext_space_model.sv ====
/*
  Extended-space decoder model: 256 bytes behind the data-space path.
  Assumes loads are answered combinationally in the cycle they are asked.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_space_model (
  // Clock
  input  wire logic       clk_i,
  // Extended access
  input  wire logic       load_i,
  input  wire logic       store_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem    [256];
  logic [7:0] last_r = 8'h00;
  // Data toggles while nothing is read, so a stale value never matches
  assign rdata_o = load_i ? mem[addr_i] : ~last_r;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
  always @(posedge clk_i) begin
    last_r <= load_i ? mem[addr_i] : ~last_r;
    if (store_i) mem[addr_i] <= wdata_i;
  end
endmodule
`default_nettype wire

// ==== testbench/tb_io_space_register_decode.sv ====
/*
  Self-checking bench for the I/O space decoder.
  Assumes the extended-space model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_io_space_register_decode;
  logic       clk_sys_i  = 1'b0;
  logic       rst_n_i    = 1'b0;
  logic [7:0] req        = 8'h00;
  logic [7:0] adr        = 8'h00;
  logic [7:0] dat        = 8'h00;
  logic [7:0] f0         = 8'h00;
  logic [7:0] f1         = 8'h00;
  logic [7:0] pin  [4]   = '{default: 8'h00};
  logic [5:0] rw_tab [8] = '{6'h01, 6'h05, 6'h0a, 6'h1e, 6'h21, 6'h2a, 6'h22, 6'h1d};
  logic [31:0] seed      = 32'h3f3e4b9f;
  logic [31:0] r;
  logic [5:0]  a;
  logic [7:0]  d;
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles    = 0;
  wire  [7:0]  io_q, ds_q, pa_dir, pb_out, t0f, t1f, ext_a, ext_wd, ext_rd, eif, msk;
  wire         skp, ext_ld, ext_st;
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  io_space_register_decode i_io_space_register_decode (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .io_addr_i(adr[5:0]), .io_rd_i(req[0]),
    .io_wr_i(req[1]), .io_wdata_i(dat), .io_rdata_o(io_q), .bit_addr_i(adr[4:0]),
    .bit_sel_i(dat[2:0]), .io_bit_set_op_i(req[4]), .io_bit_clear_op_i(req[5]),
    .skip_if_io_bit_set_i(req[6]), .skip_if_io_bit_clear_i(req[7]), .skip_o(skp),
    .ds_addr_i(adr), .data_space_load_i(req[2]), .data_space_store_i(req[3]),
    .ds_wdata_i(dat), .ds_rdata_o(ds_q), .ext_load_o(ext_ld), .ext_store_o(ext_st),
    .ext_addr_o(ext_a), .ext_wdata_o(ext_wd), .ext_rdata_i(ext_rd), .pin_a_i(pin[0]),
    .pin_b_i(pin[1]), .pin_c_i(pin[2]), .pin_d_i(pin[3]), .port_a_dir_o(pa_dir),
    .port_a_out_o(), .port_b_dir_o(), .port_b_out_o(pb_out), .port_c_dir_o(),
    .port_c_out_o(), .port_d_dir_o(), .port_d_out_o(), .timer0_flag_set_i(f0),
    .timer1_flag_set_i(f1), .timer2_flag_set_i(f0), .pin_change_flag_set_i(f0),
    .ext_irq_flag_set_i(f0), .timer0_flags_o(t0f), .timer1_flags_o(t1f),
    .timer2_flags_o(), .pin_change_flags_o(), .ext_irq_flags_o(eif), .ext_irq_mask_o(msk),
    .reg_wr_o(), .reg_wr_addr_o(), .reg_wr_data_o());
  ext_space_model i_ext_space_model (.clk_i(clk_sys_i), .load_i(ext_ld),
    .store_i(ext_st), .addr_i(ext_a), .wdata_i(ext_wd), .rdata_o(ext_rd));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] mk(input logic [5:0] l);
    return (l == 6'h22) ? 8'h0f : (l == 6'h1d) ? 8'h07 : 8'hff;
  endfunction
  function automatic logic [7:0] w1c(input logic [7:0] old, input logic [7:0] w);
    return old & ~w;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request, taken at the next rising edge; answer is settled on return
  task automatic op(input int k, input logic [7:0] l, input logic [7:0] v);
    @(negedge clk_sys_i);
    adr = l;
    dat = v;
    req[k] = 1'b1;
    @(negedge clk_sys_i);
    req = 8'h00;
  endtask
  task automatic final_report();
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    for (int p = 0; p < 4; p++) pin[p] = 8'(xs());
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    chk(pa_dir, 8'h00);
    // ******************************
    // Random traffic through direct I/O and the data-space alias
    // ******************************
    for (int i = 0; i < 40; i++) begin
      r = xs();
      a = rw_tab[r[10:8]];
      d = r[7:0] & mk(a);
      if (r[12]) op(1, {2'b00, a}, d);
      else op(3, {2'b00, a} + 8'h20, d);
      if (r[13]) begin
        op(0, {2'b00, a}, 8'h00);
        chk(io_q, d);
      end else begin
        op(2, {2'b00, a} + 8'h20, 8'h00);
        chk(ds_q, d);
      end
    end
    // ******************************
    // Reserved places and refusals
    // ******************************
    op(0, 8'h0c, 8'h00);
    chk(io_q, 8'h00);
    op(1, 8'h1d, 8'h05);
    chk(msk, 8'h05);
    op(0, 8'h3f, 8'h00);
    chk(io_q, 8'h00);
    op(2, 8'h10, 8'h00);
    chk(ds_q, 8'h00);
    op(3, 8'h21, 8'h55);
    chk(pa_dir, 8'h55);
    // ******************************
    // Flags, bit operations and skips
    // ******************************
    @(negedge clk_sys_i);
    f0 = 8'h07;
    f1 = 8'h27;
    @(negedge clk_sys_i);
    f0 = 8'h00;
    f1 = 8'h00;
    chk(t1f, 8'h27);
    chk(eif, 8'h07);
    op(1, 8'h15, 8'h02);
    chk(t0f, w1c(8'h07, 8'h02));
    op(1, 8'h15, 8'h00);
    chk(t0f, 8'h05);
    op(4, 8'h15, 8'h01);
    chk(t0f, 8'h00);
    op(5, 8'h16, 8'h00);
    chk(t1f, w1c(8'h27, 8'h26));
    op(1, 8'h05, 8'h5a);
    op(4, 8'h05, 8'h00);
    chk(pb_out, 8'h5b);
    op(5, 8'h05, 8'h06);
    chk(pb_out, 8'h1b);
    d = 8'(xs());
    op(1, 8'h1e, d);
    for (int b = 0; b < 8; b++) begin
      op(6, 8'h1e, 8'(b));
      chk({7'h00, skp}, {7'h00, d[b]});
      op(7, 8'h1e, 8'(b));
      chk({7'h00, skp}, {7'h00, !d[b]});
    end
    // ******************************
    // Extended space and pins
    // ******************************
    op(2, 8'h60, 8'h00);
    chk(ds_q, 8'h60 ^ 8'ha5);
    op(3, 8'h80, 8'h3c);
    op(2, 8'h80, 8'h00);
    chk(ds_q, 8'h3c);
    op(0, 8'h06, 8'h00);
    chk(io_q, pin[2]);
    final_report();
  end
endmodule
`default_nettype wire
